// ==== rtl/esp_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_baud
  import esp_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Configuration.
  input wire logic [1:0] mode,
  input wire logic smod,
  input wire logic [15:0] reload,
  // Ticks.
  output logic bit_tick,
  output logic overflow_tick
);

  typedef struct packed {
    logic [15:0] tmr;
    logic [7:0] cnt;
  } esp_baud_state_t;

  esp_baud_state_t s_q;
  esp_baud_state_t s_d;
  logic [7:0] div;

  always_comb begin
    s_d = s_q;
    // Two ticks per shift clock period, sixteen ticks per async bit time.
    if (mode == ESP_MODE_SYNC) begin
      div = ESP_DIV_M0 >> 1;
    end else if (smod) begin
      div = ESP_DIV_M2_FAST >> 4;
    end else begin
      div = ESP_DIV_M2_SLOW >> 4;
    end
    overflow_tick = (s_q.tmr == 16'h0000);
    s_d.tmr = overflow_tick ? reload : s_q.tmr - 16'h0001;
    bit_tick = (s_q.cnt == 8'h00);
    s_d.cnt = bit_tick ? div - 8'h01 : s_q.cnt - 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/esp_pkg.sv ====
package esp_pkg;

  // Register byte addresses.
  localparam logic [7:0] ESP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ESP_ADDR_DATA = 8'h04;
  localparam logic [7:0] ESP_ADDR_SADDR = 8'h08;
  localparam logic [7:0] ESP_ADDR_SADEN = 8'h0C;
  localparam logic [7:0] ESP_ADDR_STAT = 8'h10;
  localparam logic [7:0] ESP_ADDR_MASK = 8'h14;
  localparam logic [7:0] ESP_ADDR_BAUD = 8'h18;

  // Control register field positions.
  localparam int ESP_CTRL_RI = 0;
  localparam int ESP_CTRL_TI = 1;
  localparam int ESP_CTRL_RB8 = 2;
  localparam int ESP_CTRL_TB8 = 3;
  localparam int ESP_CTRL_REN = 4;
  localparam int ESP_CTRL_MCE = 5;
  localparam int ESP_CTRL_M0 = 6;
  localparam int ESP_CTRL_M1 = 7;
  localparam int ESP_CTRL_OVR = 8;
  localparam int ESP_CTRL_SMOD = 9;

  // Status and mask bit positions.
  localparam int ESP_ST_RX = 0;
  localparam int ESP_ST_TX = 1;
  localparam int ESP_ST_OVR = 2;

  // Reset values.
  localparam logic [9:0] ESP_CTRL_RST = 10'h000;
  localparam logic [15:0] ESP_BAUD_RST = 16'h0001;

  // Baud dividers in system clocks.
  localparam logic [7:0] ESP_DIV_M0 = 8'h0C;
  localparam logic [7:0] ESP_DIV_M2_SLOW = 8'h40;
  localparam logic [7:0] ESP_DIV_M2_FAST = 8'h20;
  localparam logic [3:0] ESP_OVS = 4'h F;

  // Modes.
  localparam logic [1:0] ESP_MODE_SYNC = 2'h0;
  localparam logic [1:0] ESP_MODE_8B = 2'h1;
  localparam logic [1:0] ESP_MODE_9F = 2'h2;
  localparam logic [1:0] ESP_MODE_9V = 2'h3;

endpackage

// ==== rtl/esp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_sync (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Level.
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [1:0] ff;
  } esp_sync_state_t;

  esp_sync_state_t s_q;
  esp_sync_state_t s_d;

  always_comb begin
    s_d.ff = {s_q.ff[0], din};
    dout = s_q.ff[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/esp_top.sv ====
// Functional notes
// - Async full-duplex, sync half-duplex, multiprocessor support.
// - Received bytes land in holding register.
// - Overrun when new byte arrives with rx-done clear while an unread byte is held; the new byte is dropped.
// - One data address: read rx, write tx.
// - Tx-done bit 1, rx-done bit 0.
// - Flags stay set until software clears.
// - Three interrupt sources, pollable.
// - Four modes with their baud clocks.
// - Sync mode: tx pin clocks, rx data.
// - Mode 1 loads only if checks pass.
// - Ninth bit marks address; masked compare.
`timescale 1ns/1ps
`default_nettype none
module esp_top
  import esp_pkg::*;
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input wire logic serial_in_pin,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe,
  output logic serial_out_pin,
  // Interrupt.
  output logic irq
);

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SYNC = 4'b0010,
    TX_ASYNC = 4'b0100,
    TX_STOP = 4'b1000
  } esp_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SYNC = 3'b010,
    RX_ASYNC = 3'b100
  } esp_rx_t;

  typedef struct packed {
    logic [9:0] ctrl;
    logic [7:0] saddr;
    logic [7:0] saden;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [15:0] baud;
    logic [7:0] rx_buf;
    logic rx_unread;
    esp_tx_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_ovs;
    logic tx_pin;
    logic sclk;
    logic ph;
    esp_rx_t rx_st;
    logic [10:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_ovs;
    logic rx_oe;
    logic [31:0] rdata;
  } esp_state_t;

  esp_state_t s_q;
  esp_state_t s_d;
  logic rx_in;
  logic bit_tick;
  logic ovf_tick;
  logic tick;
  logic [1:0] mode;
  logic nine;
  logic acc;
  logic wr;
  logic rd;
  logic rx_done;
  logic tx_done;
  logic ovr_ev;
  logic [7:0] rx_byte;
  logic rx_b8;
  logic accept;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = acc && (paddr == a) && (pwrite == r);
  endfunction

  esp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(serial_in_pin),
    .dout(rx_in)
  );

  esp_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .smod(s_q.ctrl[ESP_CTRL_SMOD]),
    .reload(s_q.baud),
    .bit_tick(bit_tick),
    .overflow_tick(ovf_tick)
  );

  always_comb begin
    s_d = s_q;
    mode = {s_q.ctrl[ESP_CTRL_M1], s_q.ctrl[ESP_CTRL_M0]};
    nine = mode[1];
    acc = psel && penable;
    wr = hit(ESP_ADDR_DATA, 1'b1);
    rd = hit(ESP_ADDR_DATA, 1'b0);
    tick = (mode == ESP_MODE_8B || mode == ESP_MODE_9V) ? ovf_tick : bit_tick;
    rx_done = 1'b0;
    tx_done = 1'b0;
    ovr_ev = 1'b0;
    rx_byte = s_q.rx_sh[7:0];
    rx_b8 = s_q.rx_sh[8];
    accept = 1'b0;
    // sync shift clock toggles on baud ticks.
    if (bit_tick) begin
      s_d.ph = ~s_q.ph;
    end
    unique case (s_q.tx_st)
      TX_IDLE: begin
        s_d.tx_pin = 1'b1;
        s_d.sclk = 1'b1;
        if (wr) begin
          s_d.tx_cnt = 4'h0;
          s_d.tx_ovs = 4'h0;
          if (mode == ESP_MODE_SYNC) begin
            s_d.tx_sh = {3'h0, pwdata[7:0]};
            s_d.tx_st = TX_SYNC;
          end else begin
            s_d.tx_sh = {1'b1, s_q.ctrl[ESP_CTRL_TB8], pwdata[7:0], 1'b0};
            s_d.tx_st = TX_ASYNC;
          end
        end
      end
      TX_SYNC: begin
        // tx pin drives clock, rx pin drives data LSB first.
        if (bit_tick) begin
          s_d.sclk = s_q.ph;
          // Shift only on a visible rising edge of the shift clock.
          if (s_q.ph && !s_q.sclk) begin
            s_d.tx_sh = {1'b0, s_q.tx_sh[10:1]};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
            if (s_q.tx_cnt == 4'h7) begin
              tx_done = 1'b1;
              s_d.tx_st = TX_IDLE;
            end
          end
        end
      end
      TX_ASYNC: begin
        if (tick) begin
          s_d.tx_ovs = s_q.tx_ovs + 4'h1;
          s_d.tx_pin = s_q.tx_sh[0];
          if (s_q.tx_ovs == ESP_OVS) begin
            s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
            if (s_q.tx_cnt == (nine ? 4'h9 : 4'h8)) begin
              // done at start of stop bit.
              tx_done = 1'b1;
              s_d.tx_pin = 1'b1;
              s_d.tx_st = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          s_d.tx_ovs = s_q.tx_ovs + 4'h1;
          if (s_q.tx_ovs == ESP_OVS) begin
            s_d.tx_st = TX_IDLE;
          end
        end
      end
      default: s_d.tx_st = TX_IDLE;
    endcase
    unique case (s_q.rx_st)
      RX_IDLE: begin
        s_d.rx_oe = 1'b0;
        s_d.rx_cnt = 4'h0;
        s_d.rx_ovs = 4'h0;
        if (s_q.ctrl[ESP_CTRL_REN]) begin
          if (mode == ESP_MODE_SYNC) begin
            if (!s_q.ctrl[ESP_CTRL_RI] && s_q.tx_st == TX_IDLE) begin
              s_d.rx_st = RX_SYNC;
            end
          end else if (!rx_in) begin
            s_d.rx_st = RX_ASYNC;
          end
        end
      end
      RX_SYNC: begin
        if (bit_tick) begin
          s_d.sclk = s_q.ph;
          if (s_q.ph && !s_q.sclk) begin
            s_d.rx_sh = {3'h0, rx_in, s_q.rx_sh[7:1]};
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt == 4'h7) begin
              rx_byte = {rx_in, s_q.rx_sh[7:1]};
              rx_b8 = s_q.ctrl[ESP_CTRL_RB8];
              accept = 1'b1;
              s_d.sclk = 1'b1;
              s_d.rx_st = RX_IDLE;
            end
          end
        end
      end
      RX_ASYNC: begin
        if (tick) begin
          s_d.rx_ovs = s_q.rx_ovs + 4'h1;
          if (s_q.rx_ovs == 4'h7) begin
            if (s_q.rx_cnt == 4'h0 && rx_in) begin
              s_d.rx_st = RX_IDLE;
            end
            s_d.rx_sh = {rx_in, s_q.rx_sh[10:1]};
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt == (nine ? 4'hA : 4'h9)) begin
              s_d.rx_st = RX_IDLE;
              rx_byte = nine ? s_q.rx_sh[10:3] : s_q.rx_sh[10:3];
              if (nine) begin
                rx_byte = s_q.rx_sh[9:2];
                rx_b8 = s_q.rx_sh[10];
              end else begin
                rx_byte = s_q.rx_sh[10:3];
                rx_b8 = rx_in;
              end
              if (!s_q.ctrl[ESP_CTRL_RI]) begin
                if (!nine) begin
                  accept = !s_q.ctrl[ESP_CTRL_MCE] || rx_in;
                end else begin
                  accept = !s_q.ctrl[ESP_CTRL_MCE] || (rx_b8 &&
                    (((rx_byte ^ s_q.saddr) & s_q.saden) == 8'h00));
                end
              end
            end
          end
        end
      end
      default: s_d.rx_st = RX_IDLE;
    endcase
    // Data moves one clock after the rising shift edge, so the far side samples it settled.
    s_d.rx_oe = (s_q.rx_st == RX_IDLE) ? (s_q.tx_st == TX_SYNC && !s_q.tx_sh[0]) :
      1'b0;
    // A read clears the unread mark; a new byte in the same cycle still sees the old mark, so it counts as overrun and is dropped.
    if (rd) begin
      s_d.rx_unread = 1'b0;
    end
    if (accept) begin
      rx_done = 1'b1;
      if (s_q.rx_unread) begin
        ovr_ev = 1'b1;
      end
      if (!(s_q.ctrl[ESP_CTRL_OVR] || s_q.rx_unread)) begin
        s_d.rx_buf = rx_byte;
        s_d.rx_unread = 1'b1;
      end
      s_d.ctrl[ESP_CTRL_RB8] = rx_b8;
    end
    // Register writes; hardware sets win over clears.
    if (hit(ESP_ADDR_CTRL, 1'b1)) begin
      s_d.ctrl = pwdata[9:0];
      if (accept) begin
        s_d.ctrl[ESP_CTRL_RB8] = rx_b8;
      end
    end
    if (hit(ESP_ADDR_SADDR, 1'b1)) s_d.saddr = pwdata[7:0];
    if (hit(ESP_ADDR_SADEN, 1'b1)) s_d.saden = pwdata[7:0];
    if (hit(ESP_ADDR_MASK, 1'b1)) s_d.mask = pwdata[2:0];
    if (hit(ESP_ADDR_BAUD, 1'b1)) s_d.baud = pwdata[15:0];
    if (hit(ESP_ADDR_STAT, 1'b1)) s_d.stat = s_q.stat & ~pwdata[2:0];
    if (tx_done) s_d.ctrl[ESP_CTRL_TI] = 1'b1;
    if (rx_done) s_d.ctrl[ESP_CTRL_RI] = 1'b1;
    if (ovr_ev) s_d.ctrl[ESP_CTRL_OVR] = 1'b1;
    s_d.stat = s_d.stat | {ovr_ev, tx_done, rx_done};
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ESP_ADDR_CTRL: s_d.rdata = {22'h00_0000, s_q.ctrl};
        ESP_ADDR_DATA: s_d.rdata = {24'h00_0000, s_q.rx_buf};
        ESP_ADDR_SADDR: s_d.rdata = {24'h00_0000, s_q.saddr};
        ESP_ADDR_SADEN: s_d.rdata = {24'h00_0000, s_q.saden};
        ESP_ADDR_STAT: s_d.rdata = {29'h0000_0000, s_q.stat};
        ESP_ADDR_MASK: s_d.rdata = {29'h0000_0000, s_q.mask};
        ESP_ADDR_BAUD: s_d.rdata = {16'h0000, s_q.baud};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end else begin
      s_d.rdata = s_q.rdata;
    end
    prdata = s_q.rdata;
    pready = 1'b1;
    pslverr = acc && !(paddr inside {ESP_ADDR_CTRL, ESP_ADDR_DATA, ESP_ADDR_SADDR,
      ESP_ADDR_SADEN, ESP_ADDR_STAT, ESP_ADDR_MASK, ESP_ADDR_BAUD});
    serial_in_pin_o = 1'b0;
    serial_in_pin_oe = s_q.rx_oe;
    serial_out_pin = (s_q.tx_st == TX_SYNC || s_q.rx_st == RX_SYNC) ? s_q.sclk :
      s_q.tx_pin;
    irq = |(s_q.stat & s_q.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= ESP_CTRL_RST;
      s_q.baud <= ESP_BAUD_RST;
      s_q.tx_st <= TX_IDLE;
      s_q.rx_st <= RX_IDLE;
      s_q.tx_pin <= 1'b1;
      s_q.sclk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== tb/enhanced_serial_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module enhanced_serial_port_tb;
  import esp_pkg::*;
  typedef struct {logic [7:0] a; bit w; logic [31:0] d; logic [31:0] e; bit err;} esp_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, sin_o, sin_oe, sout, irq, line, drv, sync_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int n_fail = 0;
  int check_count = 0;
  esp_row_t rows[7] = '{
    '{ESP_ADDR_CTRL, 0, '0, '0, 0}, '{ESP_ADDR_BAUD, 0, '0, 32'h0000_0001, 0},
    '{ESP_ADDR_STAT, 0, '0, '0, 0}, '{ESP_ADDR_SADDR, 1, 32'h0000_005A, 32'h0000_005A, 0},
    '{ESP_ADDR_SADEN, 1, 32'h0000_00FF, 32'h0000_00FF, 0},
    '{ESP_ADDR_MASK, 1, 32'h0000_0007, 32'h0000_0007, 0}, '{8'h1C, 1, 32'h0000_00FF, '0, 1}};
  esp_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(line), .serial_in_pin_o(sin_o), .serial_in_pin_oe(sin_oe),
    .serial_out_pin(sout), .irq(irq)
  );
  esp_peer peer (
    .pclk(pclk), .serial_out_pin(sout), .line_in(line), .sync_en(sync_en), .line_drv(drv)
  );
  assign line = sin_oe ? sin_o : drv;
  always #20 pclk = ~pclk;
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      $display("Error %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic poll(input int b);
    int t;
    t = 0;
    do begin
      apb(ESP_ADDR_CTRL, 1'b0, '0);
      t++;
    end while (rd[b] !== 1'b1 && t < 400);
    if (t >= 400) begin
      n_fail++;
      $display("Error %0t: flag never set", $time);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d checks, %0d failures", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    n_fail++;
    $display("Error %0t: timeout", $time);
    stop_test();
  end
  initial begin
    int n;
    int t;
    {psel, penable, pwrite, paddr, pwdata, sync_en} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, '0);
      chk(rd, rows[i].e);
      chk(32'(err), 32'(rows[i].err));
    end
    $display("Register table done");
    for (int m = 1; m < 4; m++) begin
      n = peer.n_got;
      t = 0;
      apb(ESP_ADDR_CTRL, 1'b1, 32'h0000_0218 | 32'(m << 6));
      apb(ESP_ADDR_DATA, 1'b1, 32'h0000_00A5);
      poll(ESP_CTRL_TI);
      chk(32'(rd[ESP_CTRL_TI]), 32'h0000_0001);
      while (peer.n_got == n && t < 3000) begin
        @(posedge pclk);
        t++;
      end
      if (t >= 3000) begin
        n_fail++;
        $display("Error %0t: frame not seen", $time);
      end
      // Let the stop bit finish so the next data write is not refused.
      repeat (64) @(posedge pclk);
      chk(32'(peer.got_q), 32'h0000_01A5);
      chk(32'(irq), 32'h0000_0001);
      apb(ESP_ADDR_CTRL, 1'b0, '0);
      chk(32'(rd[ESP_CTRL_TI]), 32'h0000_0001);
      apb(ESP_ADDR_STAT, 1'b1, 32'h0000_0007);
      apb(ESP_ADDR_CTRL, 1'b1, 32'h0000_0218 | 32'(m << 6));
      chk(32'(irq), '0);
    end
    $display("Transmit modes done");
    apb(ESP_ADDR_CTRL, 1'b1, 32'h0000_0298);
    peer.send(9'h03C, 32);
    poll(ESP_CTRL_RI);
    chk(32'(irq), 32'h0000_0001);
    apb(ESP_ADDR_CTRL, 1'b1, 32'h0000_0298);
    peer.send(9'h011, 32);
    poll(ESP_CTRL_OVR);
    chk(32'(rd[ESP_CTRL_OVR]), 32'h0000_0001);
    apb(ESP_ADDR_DATA, 1'b0, '0);
    chk(rd, 32'h0000_003C);
    apb(ESP_ADDR_CTRL, 1'b0, '0);
    chk(32'(rd[ESP_CTRL_OVR]), 32'h0000_0001);
    $display("Overrun done");
    apb(ESP_ADDR_CTRL, 1'b1, 32'h0000_02B8);
    peer.send(9'h03C, 32);
    peer.send(9'h15B, 32);
    peer.send(9'h15A, 32);
    poll(ESP_CTRL_RI);
    chk(32'(rd[ESP_CTRL_RB8]), 32'h0000_0001);
    apb(ESP_ADDR_DATA, 1'b0, '0);
    chk(rd, 32'h0000_005A);
    apb(ESP_ADDR_MASK, 1'b1, '0);
    chk(32'(irq), '0);
    $display("Address match done");
    apb(ESP_ADDR_CTRL, 1'b1, '0);
    sync_en <= 1'b1;
    apb(ESP_ADDR_DATA, 1'b1, 32'h0000_0096);
    poll(ESP_CTRL_TI);
    chk(32'(peer.sh_q), 32'h0000_0096);
    $display("Sync mode done");
    presetn <= 1'b0;
    @(posedge pclk);
    chk(32'({sout, sin_oe, irq}), 32'h0000_0004);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(ESP_ADDR_CTRL, 1'b0, '0);
    chk(rd, '0);
    $display("Reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== tb/esp_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_peer (
  // Clock.
  input wire logic pclk,
  // Lines.
  input wire logic serial_out_pin,
  input wire logic line_in,
  input wire logic sync_en,
  output logic line_drv
);
  logic [8:0] got_q;
  logic [7:0] sh_q;
  int n_got;
  int len;
  initial begin
    line_drv = 1'b1;
    n_got = 0;
    sh_q = 8'h00;
  end
  always @(posedge serial_out_pin) begin
    if (sync_en) begin
      sh_q = {line_in, sh_q[7:1]};
    end
  end
  always begin
    @(negedge serial_out_pin);
    if (!sync_en) begin
      len = 0;
      while (!serial_out_pin) begin
        @(posedge pclk);
        len++;
      end
      repeat (len / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        got_q[i] = serial_out_pin;
        repeat (len) @(posedge pclk);
      end
      n_got++;
    end
  end
  task automatic send(input logic [8:0] v, input int bt);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      line_drv <= f[i];
      repeat (bt - 1) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/esp_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_top_sva
  import esp_pkg::*;
(
  // Bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic serial_in_pin,
  input wire logic serial_in_pin_o,
  input wire logic serial_in_pin_oe,
  input wire logic serial_out_pin,
  input wire logic irq
);
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic mapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign mapped = (paddr <= ESP_ADDR_BAUD) && (paddr[1:0] == 2'h0);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  always_comb begin
    mode_d = mode_q;
    if (psel && penable && pwrite && paddr == ESP_ADDR_CTRL) begin
      mode_d = pwdata[7:6];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= ESP_MODE_SYNC;
    end else begin
      mode_q <= mode_d;
    end
  end
  property p_ready; s_acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; s_acc and !mapped |-> pslverr && (pwrite || prdata == 0); endproperty
  a_err: assert property (p_err) else $error("unmapped access");
  property p_noerr; s_acc and mapped |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("bad error");
  property p_hold; s_acc and !pwrite |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_odz; !serial_in_pin_o; endproperty
  a_odz: assert property (p_odz) else $error("data line driven high");
  property p_oe; mode_q != 0 && $past(mode_q) != 0 |-> !serial_in_pin_oe; endproperty
  a_oe: assert property (p_oe) else $error("data line driven");
  property p_bit; mode_q != 0 && $fell(serial_out_pin) |=> !serial_out_pin [*7]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  property p_sclk; mode_q == 0 && $changed(serial_out_pin) |=> $stable(serial_out_pin) [*5];
  endproperty
  a_sclk: assert property (p_sclk) else $error("shift clock fast");
  property p_irqm; s_wr(ESP_ADDR_MASK) and pwdata[2:0] == 3'h0 |=> !irq; endproperty
  a_irqm: assert property (p_irqm) else $error("masked irq");
endmodule
bind esp_top esp_top_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_in_pin_o(serial_in_pin_o),
  .serial_in_pin_oe(serial_in_pin_oe), .serial_out_pin(serial_out_pin), .irq(irq)
);
`default_nettype wire
